// file: shared/tw_pkg.sv
// Shared constants and types of the two-wire serial port.
package tw_pkg;

  // Byte address width of the register slave.
  localparam int TW_AW = 5;

  // Register byte offsets.
  localparam logic [4:0] TW_OFF_CTRL = 5'h00; // port_control_reg
  localparam logic [4:0] TW_OFF_STATE = 5'h04; // state_code_reg
  localparam logic [4:0] TW_OFF_DATA = 5'h08; // shift data register
  localparam logic [4:0] TW_OFF_OWN = 5'h0c; // own_address_reg
  localparam logic [4:0] TW_OFF_IST = 5'h10; // interrupt status, read only
  localparam logic [4:0] TW_OFF_ICLR = 5'h14; // interrupt clear, write only
  localparam logic [4:0] TW_OFF_IEN = 5'h18; // interrupt enable

  // Bit positions in port_control_reg.
  localparam int TW_B_CR0 = 0; // clock_rate_low_bit
  localparam int TW_B_CR1 = 1; // clock_rate_high_bit
  localparam int TW_B_ACK = 2; // assert_ack_bit
  localparam int TW_B_FLAG = 3; // serial interrupt flag
  localparam int TW_B_HALT = 4; // halt_request_bit
  localparam int TW_B_BEGIN = 5; // begin_request_bit
  localparam int TW_B_EN = 6; // port_enable_bit

  // Bit position of general_call_enable in own_address_reg.
  localparam int TW_B_GC = 0;

  // Interrupt status bits.
  localparam int TW_IRQ_N = 2;
  localparam int TW_IRQ_FLAG = 0; // a new state code was posted
  localparam int TW_IRQ_BERR = 1; // a bus error was detected

  // Reset values.
  localparam logic [7:0] TW_OWN_RST = 8'h00;
  localparam logic [7:0] TW_DATA_RST = 8'h00;
  localparam logic [1:0] TW_IEN_RST = 2'h0;

  // State codes.
  localparam logic [7:0] TW_ST_BERR = 8'h00;
  localparam logic [7:0] TW_ST_START = 8'h08;
  localparam logic [7:0] TW_ST_RSTART = 8'h10;
  localparam logic [7:0] TW_ST_AW_ACK = 8'h18;
  localparam logic [7:0] TW_ST_AW_NAK = 8'h20;
  localparam logic [7:0] TW_ST_DT_ACK = 8'h28;
  localparam logic [7:0] TW_ST_DT_NAK = 8'h30;
  localparam logic [7:0] TW_ST_AR_ACK = 8'h40;
  localparam logic [7:0] TW_ST_AR_NAK = 8'h48;
  localparam logic [7:0] TW_ST_DR_ACK = 8'h50;
  localparam logic [7:0] TW_ST_DR_NAK = 8'h58;
  localparam logic [7:0] TW_ST_SW_OWN = 8'h60;
  localparam logic [7:0] TW_ST_SW_GC = 8'h70;
  localparam logic [7:0] TW_ST_SD_ACK = 8'h80;
  localparam logic [7:0] TW_ST_SD_NAK = 8'h88;
  localparam logic [7:0] TW_ST_GD_ACK = 8'h90;
  localparam logic [7:0] TW_ST_GD_NAK = 8'h98;
  localparam logic [7:0] TW_ST_SSTOP = 8'ha0;
  localparam logic [7:0] TW_ST_SR_OWN = 8'ha8;
  localparam logic [7:0] TW_ST_ST_ACK = 8'hb8;
  localparam logic [7:0] TW_ST_ST_NAK = 8'hc0;
  localparam logic [7:0] TW_ST_NONE = 8'hf8;

  // Clock and serial clock rates selected by the two rate bits.
  localparam int TW_CLK_HZ = 10_000_000;
  localparam int TW_SCL_HZ_0 = 100_000;
  localparam int TW_SCL_HZ_1 = 50_000;
  localparam int TW_SCL_HZ_2 = 25_000;
  localparam int TW_SCL_HZ_3 = 12_500;
  localparam int TW_HALF_0 = TW_CLK_HZ / (2 * TW_SCL_HZ_0);
  localparam int TW_HALF_1 = TW_CLK_HZ / (2 * TW_SCL_HZ_1);
  localparam int TW_HALF_2 = TW_CLK_HZ / (2 * TW_SCL_HZ_2);
  localparam int TW_HALF_3 = TW_CLK_HZ / (2 * TW_SCL_HZ_3);

  // Role on the bus and phase of the bit engine.
  typedef enum logic [1:0] {TW_NAS, TW_MST, TW_SLV} tw_role_t;
  typedef enum logic [2:0] {
    TW_IDLE, TW_START, TW_LOW, TW_HIGH, TW_HOLD, TW_STOP, TW_RSTART, TW_SRX
  } tw_phase_t;

endpackage

// file: src/tw_port.sv
// Notes on behaviour
// - A START or STOP inside a byte or acknowledge slot is a bus error.
// - Bus errors count only while master or addressed slave.
// - On bus error drop to not-addressed slave and release both lines.
// - On bus error set the flag and post code 00.
// - Enable plus acknowledge bits arm the slave; rate bits pick clock.
// - Own-address register holds address and general-call enable.
// - Own address or general call match posts a code and interrupts.
// - Begin request bit starts master operation with a START.
// - Direction bit of the sent address picks transmitter or receiver.
// - Begin request instead of halt at 28 or 58 gives repeated START.
// - Each state posts a status byte usable as a branch low byte.
// - Slave transmitter gets not-acknowledge: go not addressed, release.
// - Halt plus flag clear after bus error: release, clear halt, no STOP.
// - State register reads F8 while the flag is clear.
//
// The Avalon-MM register port and the address map are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none

module tw_port
  import tw_pkg::*;
#(
  parameter int CNT_W = 10
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Avalon-MM register slave.
  input wire logic [tw_pkg::TW_AW-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Interrupt.
  output logic irq,
  // Serial clock line, open drain.
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  // Serial data line, open drain.
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe
);
  import tw_pkg::*;

  // The slowest rate must fit the bit timer.
  if (TW_HALF_3 >= (1 << CNT_W)) begin : g_chk
    $error("CNT_W too small for the slowest serial clock");
  end

  typedef struct packed {
    logic scl_s1;
    logic scl_s2;
    logic scl_s3;
    logic sda_s1;
    logic sda_s2;
    logic sda_s3;
    logic ens;
    logic begin_request_bit;
    logic halt_request_bit;
    logic si;
    logic aa;
    logic [1:0] cr;
    logic [7:0] own;
    logic [7:0] dat;
    logic [7:0] code;
    logic [7:0] sh;
    logic [TW_IRQ_N-1:0] ist;
    logic [TW_IRQ_N-1:0] ien;
    tw_role_t role;
    tw_phase_t ph;
    logic busy;
    logic tx;
    logic rd;
    logic addrp;
    logic gc;
    logic ackok;
    logic scl_oe;
    logic sda_oe;
    logic ack;
    logic [3:0] bitc;
    logic [CNT_W-1:0] cnt;
    logic [7:0] rdata;
  } tw_state_t;

  tw_state_t q;
  tw_state_t n;

  // Register read multiplexer; unmapped offsets read as zero.
  function automatic logic [7:0] tw_rd(input tw_state_t s,
                                       input logic [TW_AW-1:0] a);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      TW_OFF_CTRL: v = {1'h0, s.ens, s.begin_request_bit, s.halt_request_bit, s.si, s.aa, s.cr};
      TW_OFF_STATE: v = s.si ? s.code : TW_ST_NONE;
      TW_OFF_DATA: v = s.dat;
      TW_OFF_OWN: v = s.own;
      TW_OFF_IST: v = {{(8 - TW_IRQ_N){1'h0}}, s.ist};
      TW_OFF_IEN: v = {{(8 - TW_IRQ_N){1'h0}}, s.ien};
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  logic [CNT_W-1:0] half;
  logic tick;
  logic scl_h;
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic in_frame;
  logic match;
  logic wr_go;

  // Next-state logic of the whole port.
  always_comb begin
    n = q;
    // Line synchronisers; the second and third stages feed the logic.
    n.scl_s1 = scl_in;
    n.scl_s2 = q.scl_s1;
    n.scl_s3 = q.scl_s2;
    n.sda_s1 = sda_in;
    n.sda_s2 = q.sda_s1;
    n.sda_s3 = q.sda_s2;
    scl_h = q.scl_s2;
    scl_rise = q.scl_s2 & ~q.scl_s3;
    scl_fall = ~q.scl_s2 & q.scl_s3;
    start_c = ~q.sda_s2 & q.sda_s3 & q.scl_s2 & q.scl_s3;
    stop_c = q.sda_s2 & ~q.sda_s3 & q.scl_s2 & q.scl_s3;
    // Rate bits choose the half period of the master clock.
    case (q.cr)
      2'h0: half = CNT_W'(TW_HALF_0);
      2'h1: half = CNT_W'(TW_HALF_1);
      2'h2: half = CNT_W'(TW_HALF_2);
      default: half = CNT_W'(TW_HALF_3);
    endcase
    tick = (q.cnt == half - CNT_W'(1));
    match = 1'h0;

    // Bus slave: one wait cycle, read data captured in it.
    n.ack = (read | write) & ~q.ack;
    if ((read | write) && !q.ack) begin
      n.rdata = tw_rd(q, address);
    end
    wr_go = write & q.ack & byteenable[0];
    if (wr_go) begin
      case (address)
        TW_OFF_CTRL: begin
          n.ens = writedata[TW_B_EN];
          n.begin_request_bit = writedata[TW_B_BEGIN];
          n.halt_request_bit = writedata[TW_B_HALT];
          n.aa = writedata[TW_B_ACK];
          n.cr = {writedata[TW_B_CR1], writedata[TW_B_CR0]};
          // Software can only clear the flag, never set it.
          n.si = q.si & writedata[TW_B_FLAG];
        end
        TW_OFF_DATA: n.dat = writedata[7:0];
        TW_OFF_OWN: n.own = writedata[7:0];
        TW_OFF_ICLR: n.ist = q.ist & ~writedata[TW_IRQ_N-1:0];
        TW_OFF_IEN: n.ien = writedata[TW_IRQ_N-1:0];
        default: ;
      endcase
    end

    // Bus busy tracking from START and STOP seen on the lines.
    if (start_c) begin
      n.busy = 1'h1;
    end else if (stop_c) begin
      n.busy = 1'h0;
    end

    // A START or STOP inside a frame matters only while involved.
    // The first clock of a byte is where a STOP or repeated START sits.
    in_frame = (q.ph == TW_LOW) || (q.ph == TW_HIGH) ||
               ((q.ph == TW_SRX) && (q.bitc > 4'h1));
    if (!q.ens) begin
      n.role = TW_NAS;
      n.ph = TW_IDLE;
      n.scl_oe = 1'h0;
      n.sda_oe = 1'h0;
    end else if ((start_c || stop_c) && in_frame &&
                 (q.role != TW_NAS)) begin
      n.role = TW_NAS;
      n.ph = TW_IDLE;
      n.scl_oe = 1'h0;
      n.sda_oe = 1'h0;
      n.si = 1'h1;
      n.code = TW_ST_BERR;
      n.ist[TW_IRQ_BERR] = 1'h1;
      n.ist[TW_IRQ_FLAG] = 1'h1;
    end else if ((start_c || stop_c) && (q.ph == TW_SRX) &&
                 (q.role == TW_SLV)) begin
      // STOP or repeated START between bytes ends the slave transfer;
      // the clock is held low like for every posted code but 00.
      n.role = TW_NAS;
      n.ph = TW_HOLD;
      n.sda_oe = 1'h0;
      n.scl_oe = 1'h1;
      n.si = 1'h1;
      n.code = TW_ST_SSTOP;
      n.ist[TW_IRQ_FLAG] = 1'h1;
    end else if ((start_c || stop_c) && (q.role == TW_NAS) &&
                 ((q.ph == TW_IDLE) || (q.ph == TW_SRX))) begin
      // Snooping: arm address capture only when enabled to answer.
      n.ph = TW_IDLE;
      if (start_c && q.aa && !q.si) begin
        n.ph = TW_SRX;
        n.bitc = 4'h0;
        n.addrp = 1'h1;
        n.tx = 1'h0;
        n.sda_oe = 1'h0;
      end
    end else begin
      case (q.ph)
        TW_IDLE: begin
          n.cnt = '0;
          if (q.begin_request_bit && !q.busy && !q.si && q.role == TW_NAS) begin
            n.ph = TW_START;
          end else if (q.halt_request_bit && !q.si) begin
            // Recovery: lines are already free, so no STOP is sent.
            n.halt_request_bit = 1'h0;
          end
        end
        TW_START: begin
          n.sda_oe = 1'h1;
          n.cnt = q.cnt + CNT_W'(1);
          if (tick) begin
            n.cnt = '0;
            n.scl_oe = 1'h1;
            n.role = TW_MST;
            n.addrp = 1'h1;
            n.ph = TW_HOLD;
            n.si = 1'h1;
            n.code = TW_ST_START;
            n.ist[TW_IRQ_FLAG] = 1'h1;
          end
        end
        TW_HOLD: begin
          // Clock stays low while software looks at the code.
          n.scl_oe = 1'h1;
          n.cnt = '0;
          n.bitc = 4'h0;
          if (!q.si) begin
            if (q.role == TW_MST && q.halt_request_bit) begin
              n.ph = TW_STOP;
              n.sda_oe = 1'h1;
            end else if (q.role == TW_MST && q.begin_request_bit && !q.addrp) begin
              n.ph = TW_RSTART;
              n.sda_oe = 1'h0;
            end else if (q.role == TW_MST) begin
              n.ph = TW_LOW;
              n.sh = q.dat;
              n.tx = q.addrp | ~q.rd;
            end else if (q.role == TW_SLV) begin
              n.ph = TW_SRX;
              n.sh = q.dat;
              n.tx = q.rd;
              n.sda_oe = q.rd & ~q.dat[7];
              n.scl_oe = 1'h0;
            end else begin
              n.ph = TW_IDLE;
              n.scl_oe = 1'h0;
              n.sda_oe = 1'h0;
            end
          end
        end
        TW_LOW: begin
          // Data changes only while the clock is held low.
          n.scl_oe = 1'h1;
          if (q.bitc < 4'h8) begin
            n.sda_oe = q.tx & ~q.sh[7];
          end else begin
            n.sda_oe = ~q.tx & q.aa;
          end
          n.cnt = q.cnt + CNT_W'(1);
          if (tick) begin
            n.cnt = '0;
            n.scl_oe = 1'h0;
            n.ph = TW_HIGH;
          end
        end
        TW_HIGH: begin
          // A slave stretching the clock delays the high half.
          n.cnt = scl_h ? q.cnt + CNT_W'(1) : '0;
          if (tick && scl_h) begin
            n.cnt = '0;
            if (q.bitc < 4'h8) begin
              n.sh = {q.sh[6:0], q.sda_s2};
              n.bitc = q.bitc + 4'h1;
              n.ph = TW_LOW;
              n.scl_oe = 1'h1;
            end else begin
              n.ph = TW_HOLD;
              n.scl_oe = 1'h1;
              n.si = 1'h1;
              n.ist[TW_IRQ_FLAG] = 1'h1;
              n.addrp = 1'h0;
              if (q.addrp) begin
                n.rd = q.dat[0];
                if (q.dat[0]) begin
                  n.code = ~q.sda_s2 ? TW_ST_AR_ACK : TW_ST_AR_NAK;
                end else begin
                  n.code = ~q.sda_s2 ? TW_ST_AW_ACK : TW_ST_AW_NAK;
                end
              end else if (q.tx) begin
                n.code = ~q.sda_s2 ? TW_ST_DT_ACK : TW_ST_DT_NAK;
              end else begin
                n.dat = q.sh;
                n.code = ~q.sda_s2 ? TW_ST_DR_ACK : TW_ST_DR_NAK;
              end
            end
          end
        end
        TW_STOP, TW_RSTART: begin
          // Three half periods: release clock, move data, finish.
          n.cnt = q.cnt + CNT_W'(1);
          case (q.bitc)
            4'h0: begin
              if (tick) begin
                n.cnt = '0;
                n.scl_oe = 1'h0;
                n.bitc = 4'h1;
              end
            end
            4'h1: begin
              if (!scl_h) begin
                n.cnt = '0;
              end else if (tick) begin
                n.cnt = '0;
                n.sda_oe = (q.ph == TW_RSTART);
                n.bitc = 4'h2;
              end
            end
            default: begin
              if (tick && q.ph == TW_STOP) begin
                n.role = TW_NAS;
                n.ph = TW_IDLE;
                n.halt_request_bit = 1'h0;
              end else if (tick) begin
                n.scl_oe = 1'h1;
                n.addrp = 1'h1;
                n.ph = TW_HOLD;
                n.si = 1'h1;
                n.code = TW_ST_RSTART;
                n.ist[TW_IRQ_FLAG] = 1'h1;
              end
            end
          endcase
        end
        TW_SRX: begin
          match = ((q.sh[7:1] == q.own[7:1]) ||
                   (q.sh == 8'h00 && q.own[TW_B_GC]));
          if (scl_rise && q.bitc < 4'h8) begin
            n.sh = {q.sh[6:0], q.sda_s2};
            n.bitc = q.bitc + 4'h1;
          end else if (scl_rise && q.bitc == 4'h8) begin
            n.ackok = ~q.sda_s2;
            n.bitc = 4'h9;
          end else if (scl_fall && q.bitc < 4'h8) begin
            n.sda_oe = q.tx & ~q.sh[7];
          end else if (scl_fall && q.bitc == 4'h8) begin
            // Acknowledge slot: answer for address or data.
            if (q.tx) begin
              n.sda_oe = 1'h0;
            end else if (q.addrp) begin
              if (match && q.aa) begin
                n.sda_oe = 1'h1;
                n.role = TW_SLV;
                n.rd = q.sh[0];
                n.gc = (q.sh[7:1] == 7'h00);
              end else begin
                n.ph = TW_IDLE;
              end
            end else begin
              n.sda_oe = q.aa;
            end
          end else if (scl_fall && q.bitc == 4'h9) begin
            n.sda_oe = 1'h0;
            n.scl_oe = 1'h1;
            n.ph = TW_HOLD;
            n.si = 1'h1;
            n.ist[TW_IRQ_FLAG] = 1'h1;
            n.addrp = 1'h0;
            if (q.addrp) begin
              n.code = q.rd ? TW_ST_SR_OWN :
                       (q.gc ? TW_ST_SW_GC : TW_ST_SW_OWN);
            end else if (q.tx) begin
              n.code = q.ackok ? TW_ST_ST_ACK : TW_ST_ST_NAK;
              // Not-acknowledge ends slave transmit.
              if (!q.ackok) begin
                n.role = TW_NAS;
              end
            end else begin
              n.dat = q.sh;
              if (q.aa) begin
                n.code = q.gc ? TW_ST_GD_ACK : TW_ST_SD_ACK;
              end else begin
                n.code = q.gc ? TW_ST_GD_NAK : TW_ST_SD_NAK;
                n.role = TW_NAS;
              end
            end
          end
        end
        default: n.ph = TW_IDLE;
      endcase
    end
  end

  // State register; every field starts from a constant.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
      q.own <= TW_OWN_RST;
      q.dat <= TW_DATA_RST;
      q.ien <= TW_IEN_RST;
      q.code <= TW_ST_NONE;
      q.scl_s1 <= 1'h1;
      q.scl_s2 <= 1'h1;
      q.scl_s3 <= 1'h1;
      q.sda_s1 <= 1'h1;
      q.sda_s2 <= 1'h1;
      q.sda_s3 <= 1'h1;
    end else begin
      q <= n;
    end
  end

  // Open-drain lines only ever pull low.
  assign scl_out = 1'h0;
  assign sda_out = 1'h0;
  assign scl_oe = q.scl_oe;
  assign sda_oe = q.sda_oe;
  assign readdata = {24'h000000, q.rdata};
  assign waitrequest = (read | write) & ~q.ack;
  // Level interrupt while any enabled sticky bit stands.
  assign irq = |(q.ist & q.ien);

endmodule

`default_nettype wire

// file: test/tw_port_monitor.sv
`timescale 1ns/1ns
`default_nettype none

module tw_port_monitor
  import tw_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Register bus.
  input wire logic [tw_pkg::TW_AW-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic irq,
  // Serial lines.
  input wire logic scl_in,
  input wire logic scl_out,
  input wire logic scl_oe,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe
);
  logic rd_st, wr_ctl, held_q, held_d;
  logic [7:0] code_q, code_d;

  // Accepted state reads and control writes.
  assign rd_st = read && !waitrequest && address == TW_OFF_STATE;
  assign wr_ctl = write && !waitrequest && address == TW_OFF_CTRL;

  // A posted code other than 00 means the flag stays up until software
  // writes control; only software can clear it, so this is safe.
  always_comb begin
    held_d = held_q;
    code_d = code_q;
    if (rd_st && !held_q && readdata[7:0] != TW_ST_NONE &&
        readdata[7:0] != TW_ST_BERR) begin
      held_d = 1'b1;
      code_d = readdata[7:0];
    end
    if (wr_ctl) begin
      held_d = 1'b0;
    end
  end

  // Shadow of the flag as software last saw it.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      held_q <= 1'b0;
      code_q <= 8'h00;
    end else begin
      held_q <= held_d;
      code_q <= code_d;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_req;
    (read || write) && waitrequest;
  endsequence
  sequence s_rd_ok;
    read && !waitrequest;
  endsequence

  property p_wait;
    s_req |=> !waitrequest;
  endproperty
  property p_hi0;
    s_rd_ok |-> readdata[31:8] == 24'h0;
  endproperty
  property p_code8;
    s_rd_ok ##0 address == TW_OFF_STATE |-> readdata[2:0] == 3'h0;
  endproperty
  property p_hold;
    held_q |-> scl_oe;
  endproperty
  property p_stable;
    held_q && rd_st |-> readdata[7:0] == code_q;
  endproperty
  property p_berr;
    rd_st && readdata[7:0] == TW_ST_BERR |-> !scl_oe && !sda_oe ##1 !scl_oe;
  endproperty
  property p_od;
    scl_out == 1'b0 && sda_out == 1'b0;
  endproperty
  property p_ien;
    write && !waitrequest && address == TW_OFF_IEN && byteenable[0] &&
      writedata[1:0] == 2'h0 |=> !irq [*2];
  endproperty

  a_wait: assert property (p_wait) else $error("wait state too long");
  a_hi0: assert property (p_hi0) else $error("upper read bits set");
  a_code8: assert property (p_code8) else $error("code not a step of 8");
  a_hold: assert property (p_hold) else $error("clock let go with flag");
  a_stable: assert property (p_stable) else $error("code moved with flag");
  a_berr: assert property (p_berr) else $error("lines held after error");
  a_od: assert property (p_od) else $error("line driven high");
  a_ien: assert property (p_ien) else $error("irq despite zero enable");
endmodule

bind tw_port tw_port_monitor u_mon (.clk(clk), .rst(rst), .address(address),
  .read(read), .write(write), .byteenable(byteenable),
  .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
  .irq(irq), .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe));

`default_nettype wire

// file: test/tw_peer.sv
`timescale 1ns/1ns
`default_nettype none

module tw_peer (
  // Clock.
  input wire logic clk,
  // Wire levels of the serial lines.
  input wire logic scl,
  input wire logic sda,
  // Pull-down enables of this device.
  output logic scl_oe,
  output logic sda_oe
);
  // Released lines float up to the pull-up level.
  initial begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
  end

  // Half of the 800 ns link clock.
  task hb;
    repeat (4) @(posedge clk);
  endtask

  // The port may stretch the clock, so wait for the line, bounded.
  task wt;
    for (int k = 0; k < 20000 && !scl; k++) @(posedge clk);
  endtask

  // START, plain or repeated; also used as a stray one mid byte.
  task start;
    sda_oe <= 1'b0;
    hb;
    scl_oe <= 1'b0;
    wt;
    hb;
    sda_oe <= 1'b1;
    hb;
    scl_oe <= 1'b1;
    hb;
  endtask

  task stop;
    sda_oe <= 1'b1;
    hb;
    scl_oe <= 1'b0;
    wt;
    hb;
    sda_oe <= 1'b0;
    hb;
  endtask

  // One clock as master; data is set only while the clock is low.
  task xbit(input logic b, output logic r);
    sda_oe <= !b;
    hb;
    scl_oe <= 1'b0;
    wt;
    hb;
    r = sda;
    scl_oe <= 1'b1;
  endtask

  task xbyte(input logic [7:0] v, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) xbit(v[i], r);
    xbit(1'b1, r);
    ack = !r;
  endtask

  // As addressed slave: acknowledge after the eighth falling clock.
  task sack;
    int n;
    logic p;
    n = 0;
    p = scl;
    for (int k = 0; k < 20000 && n < 9; k++) begin
      @(posedge clk);
      if (p && !scl) begin
        n++;
        sda_oe <= (n == 8);
      end
      p = scl;
    end
  endtask
endmodule

`default_nettype wire

// file: test/tw_port_tb.sv
`timescale 1ns/1ns
`default_nettype none

module tw_port_tb;
  import tw_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] address = 5'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [3:0] byteenable = 4'h1;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata;
  logic waitrequest, irq, scl_oe, sda_oe, scl_o, sda_o, p_scl, p_sda;
  wire logic scl, sda;
  logic [7:0] d;
  logic ak;
  int fails = 0;
  int cmp_count = 0;

  // Open drain: any enabled driver pulls the line low.
  assign scl = !(scl_oe || p_scl);
  assign sda = !(sda_oe || p_sda);

  always #50 clk = ~clk;

  tw_port u_dut (.clk(clk), .rst(rst), .address(address), .read(read),
    .write(write), .byteenable(byteenable), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .irq(irq),
    .scl_in(scl), .scl_out(scl_o), .scl_oe(scl_oe), .sda_in(sda),
    .sda_out(sda_o), .sda_oe(sda_oe));
  tw_peer u_peer (.clk(clk), .scl(scl), .sda(sda), .scl_oe(p_scl),
    .sda_oe(p_sda));

  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask

  task tally_and_finish;
    $display("Compared %0d, mismatched %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Hold the request until waitrequest is seen low, then release.
  // Only the watchdog ends a wait that never gets its answer.
  task acc;
    do @(posedge clk); while (waitrequest !== 1'b0);
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task bw(input logic [4:0] a, input logic [7:0] v);
    @(posedge clk);
    address <= a;
    writedata <= {24'h0, v};
    write <= 1'b1;
    acc;
  endtask

  task rdchk(input string n, input logic [4:0] a, input logic [7:0] e);
    @(posedge clk);
    address <= a;
    read <= 1'b1;
    acc;
    chk(n, readdata[7:0], e);
  endtask

  // Wait for the interrupt, check the sticky causes, then clear them.
  task wflag(input logic [7:0] e);
    for (int k = 0; k < 5000 && !irq; k++) @(posedge clk);
    chk("irq", irq, 1'b1);
    rdchk("ist", TW_OFF_IST, e);
    bw(TW_OFF_ICLR, 8'h03);
  endtask

  task t_reset;
    rdchk("state", TW_OFF_STATE, TW_ST_NONE);
    rdchk("own", TW_OFF_OWN, TW_OWN_RST);
    rdchk("ien", TW_OFF_IEN, 8'h00);
    rdchk("hole", 5'h1c, 8'h00);
    bw(TW_OFF_STATE, 8'h55);
    rdchk("state_ro", TW_OFF_STATE, TW_ST_NONE);
  endtask

  // A foreign address and a stray START must leave the port idle.
  task t_foreign;
    bw(TW_OFF_OWN, 8'ha5);
    bw(TW_OFF_IEN, 8'h03);
    bw(TW_OFF_CTRL, 8'h44);
    u_peer.start;
    u_peer.xbyte(8'h20, ak);
    chk("foreign_ack", ak, 1'b0);
    u_peer.xbit(1'b1, ak);
    u_peer.start;
    repeat (50) @(posedge clk);
    chk("no_irq", irq, 1'b0);
    u_peer.stop;
  endtask

  // Addressed as receiver, then a START inside the data byte.
  task t_berr;
    u_peer.start;
    u_peer.xbyte(8'ha4, ak);
    chk("own_ack", ak, 1'b1);
    wflag(8'h01);
    rdchk("own_w", TW_OFF_STATE, TW_ST_SW_OWN);
    chk("held", scl_oe, 1'b1);
    bw(TW_OFF_CTRL, 8'h44);
    u_peer.xbit(1'b1, ak);
    u_peer.start;
    wflag(8'h03);
    rdchk("berr", TW_OFF_STATE, TW_ST_BERR);
    chk("lines", {scl_oe, sda_oe}, 2'b00);
    bw(TW_OFF_CTRL, 8'h54);
    rdchk("halt", TW_OFF_CTRL, 8'h44);
    rdchk("idle", TW_OFF_STATE, TW_ST_NONE);
    chk("no_stop", {scl_oe, sda_oe}, 2'b00);
    u_peer.stop;
  endtask

  // General call, then own read ending in a not-acknowledge.
  task t_slave_tx;
    u_peer.start;
    u_peer.xbyte(8'h00, ak);
    wflag(8'h01);
    rdchk("gc", TW_OFF_STATE, TW_ST_SW_GC);
    bw(TW_OFF_CTRL, 8'h44);
    u_peer.stop;
    wflag(8'h01);
    rdchk("stop", TW_OFF_STATE, TW_ST_SSTOP);
    bw(TW_OFF_CTRL, 8'h44);
    u_peer.start;
    u_peer.xbyte(8'ha5, ak);
    wflag(8'h01);
    rdchk("own_r", TW_OFF_STATE, TW_ST_SR_OWN);
    bw(TW_OFF_DATA, 8'h3c);
    bw(TW_OFF_CTRL, 8'h44);
    for (int i = 7; i >= 0; i--) u_peer.xbit(1'b1, d[i]);
    chk("tx_data", d, 8'h3c);
    u_peer.xbit(1'b1, ak);
    wflag(8'h01);
    rdchk("nak", TW_OFF_STATE, TW_ST_ST_NAK);
    bw(TW_OFF_CTRL, 8'h44);
    repeat (20) @(posedge clk);
    chk("sda_free", sda_oe, 1'b0);
    u_peer.stop;
  endtask

  // Master write of address and one byte, then a repeated START.
  task t_master;
    bw(TW_OFF_CTRL, 8'h64);
    wflag(8'h01);
    rdchk("start", TW_OFF_STATE, TW_ST_START);
    bw(TW_OFF_DATA, 8'h90);
    fork u_peer.sack; join_none
    bw(TW_OFF_CTRL, 8'h44);
    wflag(8'h01);
    rdchk("aw_ack", TW_OFF_STATE, TW_ST_AW_ACK);
    bw(TW_OFF_DATA, 8'h11);
    fork u_peer.sack; join_none
    bw(TW_OFF_CTRL, 8'h44);
    wflag(8'h01);
    rdchk("dt_ack", TW_OFF_STATE, TW_ST_DT_ACK);
    bw(TW_OFF_CTRL, 8'h64);
    wflag(8'h01);
    rdchk("rstart", TW_OFF_STATE, TW_ST_RSTART);
    bw(TW_OFF_DATA, 8'h91);
    fork u_peer.sack; join_none
    bw(TW_OFF_CTRL, 8'h44);
    wflag(8'h01);
    rdchk("ar_ack", TW_OFF_STATE, TW_ST_AR_ACK);
    bw(TW_OFF_CTRL, 8'h40);
    wflag(8'h01);
    rdchk("dr_nak", TW_OFF_STATE, TW_ST_DR_NAK);
    rdchk("rx_data", TW_OFF_DATA, 8'hff);
    bw(TW_OFF_CTRL, 8'h64);
    wflag(8'h01);
    rdchk("rstart58", TW_OFF_STATE, TW_ST_RSTART);
    bw(TW_OFF_IEN, 8'h00);
  endtask

  // Main sequence after a ten-cycle reset.
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_reset;
    t_foreign;
    t_berr;
    t_slave_tx;
    t_master;
    tally_and_finish;
  end

  // The whole run needs well under this span; a hang ends here.
  initial begin
    #8_000_000;
    fails++;
    tally_and_finish;
  end
endmodule

`default_nettype wire
